// file: sspc_regs.vh
// Sleep-state pin control: register map, field positions, encodings
// How it works
// - The S0 idle indicator and deep idle gate stay high in S0 and go low in S0i3 only when all idle criteria are met.
// - The S4 sleep indicator is driven low in S4 and in S5.
// - The S5 sleep indicator is driven high in S4 and low in S5.
// - On Deep Sx entry the S4 and S5 indicators keep the levels they held just before.
// - Outside Deep Sx mode the AC detect pin is driven low during reset instead of floating.
// - The power-down acknowledge stays 0 while the engine is full on or low power; when off it follows the wake logic.
// - The shared suspend pin starts as power-down acknowledge; with Deep Sx support later boots start as suspend warning.
// - AC detect, network wake and PCIe wake pull-downs are on in Deep Sx only when their config bit enables them.
// - Both core voltage-select outputs reset to 1 (1.8 V) and may later select 1.8 V or 3.3 V by processor and power state.
// - In S4/S5 and Deep Sx the always-on sleep indicator shows whether the engine is kept on in Sx.
// - Each pin is reset from its well: primary from resume reset, deep-sleep well from its power good, RTC well from RTC reset.
// - The deep idle gate may float high after resume reset and is driven to its gate level once its buffer enters native mode.
`ifndef SSPC_REGS_VH
`define SSPC_REGS_VH

////////////////////////////////////////////////////////////////////////
// Register byte offsets and configuration register reset value
`define SSPC_CFG_OFF 8'h00
`define SSPC_STAT_OFF 8'h04
`define SSPC_CFG_RST 8'h60

////////////////////////////////////////////////////////////////////////
// Configuration fields
`define SSPC_CFG_AC_PD 0
`define SSPC_CFG_LAN_PD 1
`define SSPC_CFG_PCIE_PD 2
`define SSPC_CFG_ENG_ON_SX 3
`define SSPC_CFG_DSX_SUP 4
`define SSPC_CFG_VID0 5
`define SSPC_CFG_VID1 6
`define SSPC_CFG_DSX_MODE 7

////////////////////////////////////////////////////////////////////////
// Platform power states
`define SSPC_PS_S0 3'h0
`define SSPC_PS_S0I3 3'h1
`define SSPC_PS_S4 3'h2
`define SSPC_PS_S5 3'h3
`define SSPC_PS_DSX 3'h4

// Management engine states
`define SSPC_ENG_FULL_ON 2'h0
`define SSPC_ENG_LOW_PWR 2'h1
`define SSPC_ENG_OFF 2'h2

`endif

// file: sspc_top.v
// Sleep-state pin controller with APB configuration and status
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "sspc_regs.vh"

module sspc_top (
	input wire ref_clk,
	input wire resetn,
	input wire clk_en,
	input wire resume_well_reset_n,
	input wire deep_sleep_well_power_good,
	input wire rtc_well_reset_n,
	input wire [2:0] platform_state,
	input wire idle_criteria_met,
	input wire [1:0] engine_state,
	input wire powerdown_ack_req,
	input wire suspend_warn_req,
	input wire gate_native_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg s0_idle_indicator_n,
	output reg processor_deep_idle_gate_n,
	output reg processor_deep_idle_gate_oe,
	output reg platform_reset_n,
	output reg s3_sleep_indicator_n,
	output reg s4_sleep_indicator_n,
	output reg s5_sleep_indicator_n,
	output reg always_on_domain_sleep_n,
	output reg suspend_well_sleep_n,
	output reg core_voltage_select_bit0,
	output reg core_voltage_select_bit1,
	output reg suspend_pin_level,
	output reg suspend_warn_mode,
	output reg ac_adapter_detect_o,
	output reg ac_adapter_detect_oe,
	output reg ac_adapter_detect_pd_en,
	output reg network_wake_pd_en,
	output reg pcie_wake_pd_en
);

////////////////////////////////////////////////////////////////////////
// Helpers

function is_run;
	input [2:0] st;
	begin
		is_run = (st == `SSPC_PS_S0) ||
			(st == `SSPC_PS_S0I3);
	end
endfunction

function is_dsx;
	input [2:0] st;
	begin
		is_dsx = (st == `SSPC_PS_DSX);
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Per-well reset synchronisers
// Assert at once, release two edges later so well logic
// never sees a release racing the clock.

wire prim_arst_n;
wire dsw_arst_n;
wire rtc_arst_n;
reg [1:0] prim_sync_r;
reg [1:0] dsw_sync_r;
reg [1:0] rtc_sync_r;
wire prim_rst_n;
wire dsw_rst_n;
wire rtc_rst_n;

assign prim_arst_n = resetn & resume_well_reset_n;
assign dsw_arst_n = resetn & deep_sleep_well_power_good;
assign rtc_arst_n = resetn & rtc_well_reset_n;

always @(posedge ref_clk or negedge prim_arst_n) begin
	if (!prim_arst_n)
		prim_sync_r <= 2'h0;
	else if (clk_en)
		prim_sync_r <= {prim_sync_r[0], 1'b1};
end

always @(posedge ref_clk or negedge dsw_arst_n) begin
	if (!dsw_arst_n)
		dsw_sync_r <= 2'h0;
	else if (clk_en)
		dsw_sync_r <= {dsw_sync_r[0], 1'b1};
end

always @(posedge ref_clk or negedge rtc_arst_n) begin
	if (!rtc_arst_n)
		rtc_sync_r <= 2'h0;
	else if (clk_en)
		rtc_sync_r <= {rtc_sync_r[0], 1'b1};
end

// Only the second stage is read, never the first
assign prim_rst_n = prim_sync_r[1];
assign dsw_rst_n = dsw_sync_r[1];
assign rtc_rst_n = rtc_sync_r[1];

////////////////////////////////////////////////////////////////////////
// Configuration register, RTC well
// Kept in the RTC well so Deep Sx settings survive
// primary and deep-sleep well power loss.

reg [7:0] cfg_r;
wire acc_go;
wire hit_cfg;
wire hit_stat;
wire [11:0] stat_w;

// Strobe drops once pready is up, so each access is taken once
assign acc_go = psel & penable & ~pready;
assign hit_cfg = (paddr == `SSPC_CFG_OFF);
assign hit_stat = (paddr == `SSPC_STAT_OFF);

always @(posedge ref_clk or negedge rtc_rst_n) begin
	if (!rtc_rst_n)
		cfg_r <= `SSPC_CFG_RST;
	else if (clk_en && acc_go && pwrite && hit_cfg)
		cfg_r <= pwdata[7:0];
end

////////////////////////////////////////////////////////////////////////
// APB slave: one wait state, answer from flops

assign stat_w = {core_voltage_select_bit1,
	core_voltage_select_bit0, suspend_warn_mode,
	suspend_pin_level, suspend_well_sleep_n,
	always_on_domain_sleep_n, s5_sleep_indicator_n,
	s4_sleep_indicator_n, s3_sleep_indicator_n,
	platform_reset_n, processor_deep_idle_gate_n,
	s0_idle_indicator_n};

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end else if (clk_en) begin
		pready <= acc_go;
		if (acc_go) begin
			// Unmapped offsets error out and read back zero
			pslverr <= ~(hit_cfg | hit_stat);
			if (pwrite || !(hit_cfg || hit_stat))
				prdata <= 32'h00000000;
			else if (hit_cfg)
				prdata <= {24'h000000, cfg_r};
			else
				prdata <= {20'h00000, stat_w};
		end else begin
			pslverr <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Primary well pins

reg susp_init_r;
wire run_st;
wire idle_ok;

assign run_st = is_run(platform_state);
assign idle_ok = (platform_state == `SSPC_PS_S0I3) &
	idle_criteria_met;

always @(posedge ref_clk or negedge prim_rst_n) begin
	if (!prim_rst_n) begin
		s0_idle_indicator_n <= 1'b1;
		processor_deep_idle_gate_n <= 1'b0;
		processor_deep_idle_gate_oe <= 1'b0;
		platform_reset_n <= 1'b0;
		core_voltage_select_bit0 <= 1'b1;
		core_voltage_select_bit1 <= 1'b1;
		suspend_pin_level <= 1'b0;
		suspend_warn_mode <= 1'b0;
		susp_init_r <= 1'b0;
	end else if (clk_en) begin
		s0_idle_indicator_n <= ~idle_ok;
		// High in S0 and in S0i3 until idle criteria are met; low otherwise
		processor_deep_idle_gate_n <= run_st & ~idle_ok;
		// Buffer floats until native mode; pin reads high
		if (gate_native_en)
			processor_deep_idle_gate_oe <= 1'b1;
		// Platform reset released only in the running states
		platform_reset_n <= run_st;
		// Outside S0 and S0i3 fall back to the safe 1.8 V select
		if (run_st) begin
			core_voltage_select_bit0 <=
				cfg_r[`SSPC_CFG_VID0];
			core_voltage_select_bit1 <=
				cfg_r[`SSPC_CFG_VID1];
		end else begin
			core_voltage_select_bit0 <= 1'b1;
			core_voltage_select_bit1 <= 1'b1;
		end
		// Mode is latched once per boot, never mid-run
		if (!susp_init_r) begin
			susp_init_r <= 1'b1;
			suspend_warn_mode <=
				cfg_r[`SSPC_CFG_DSX_SUP];
		end
		// Warning mode: pin low asks for power-loss prep
		if (suspend_warn_mode)
			suspend_pin_level <= ~suspend_warn_req;
		else if (engine_state == `SSPC_ENG_OFF)
			suspend_pin_level <= powerdown_ack_req;
		else
			suspend_pin_level <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// Deep-sleep well pins

wire dsx_st;
wire eng_on_sx;

assign dsx_st = is_dsx(platform_state);
assign eng_on_sx = cfg_r[`SSPC_CFG_ENG_ON_SX];

always @(posedge ref_clk or negedge dsw_rst_n) begin
	if (!dsw_rst_n) begin
		s3_sleep_indicator_n <= 1'b0;
		s4_sleep_indicator_n <= 1'b0;
		s5_sleep_indicator_n <= 1'b0;
		always_on_domain_sleep_n <= 1'b0;
		suspend_well_sleep_n <= 1'b0;
		ac_adapter_detect_pd_en <= 1'b0;
		network_wake_pd_en <= 1'b0;
		pcie_wake_pd_en <= 1'b0;
	end else if (clk_en) begin
		// Suspend well sleeps only in Deep Sx
		s3_sleep_indicator_n <= run_st;
		suspend_well_sleep_n <= ~dsx_st;
		case (platform_state)
		`SSPC_PS_S0, `SSPC_PS_S0I3: begin
			s4_sleep_indicator_n <= 1'b1;
			s5_sleep_indicator_n <= 1'b1;
			always_on_domain_sleep_n <= 1'b1;
		end
		`SSPC_PS_S4: begin
			s4_sleep_indicator_n <= 1'b0;
			s5_sleep_indicator_n <= 1'b1;
			always_on_domain_sleep_n <= eng_on_sx;
		end
		`SSPC_PS_S5: begin
			s4_sleep_indicator_n <= 1'b0;
			s5_sleep_indicator_n <= 1'b0;
			always_on_domain_sleep_n <= eng_on_sx;
		end
		`SSPC_PS_DSX: begin
			// S4/S5 levels held from before entry
			s4_sleep_indicator_n <= s4_sleep_indicator_n;
			s5_sleep_indicator_n <= s5_sleep_indicator_n;
			always_on_domain_sleep_n <= eng_on_sx;
		end
		default: begin
			// Unknown code: hold, never glitch a rail
			s4_sleep_indicator_n <= s4_sleep_indicator_n;
			s5_sleep_indicator_n <= s5_sleep_indicator_n;
			always_on_domain_sleep_n <=
				always_on_domain_sleep_n;
		end
		endcase
		// Pull-downs only matter once the upper wells are off
		ac_adapter_detect_pd_en <= dsx_st &
			cfg_r[`SSPC_CFG_AC_PD];
		network_wake_pd_en <= dsx_st &
			cfg_r[`SSPC_CFG_LAN_PD];
		pcie_wake_pd_en <= dsx_st &
			cfg_r[`SSPC_CFG_PCIE_PD];
	end
end

////////////////////////////////////////////////////////////////////////
// AC detect drive, RTC well
// Lives outside the deep-sleep well so it can act while
// that well is still in reset.

always @(posedge ref_clk or negedge rtc_rst_n) begin
	if (!rtc_rst_n) begin
		ac_adapter_detect_o <= 1'b0;
		ac_adapter_detect_oe <= 1'b0;
	end else if (clk_en) begin
		// Level is fixed low; only the enable moves
		ac_adapter_detect_o <= 1'b0;
		ac_adapter_detect_oe <= ~dsw_rst_n &
			~cfg_r[`SSPC_CFG_DSX_MODE];
	end
end

endmodule // sspc_top

// file: sspc_chk.sv
// Assertions on the sleep-state pin outputs
`timescale 1ns/10ps
`include "sspc_regs.vh"
module sspc_chk (
	input logic ref_clk,
	input logic resetn,
	input logic clk_en,
	input logic resume_well_reset_n,
	input logic deep_sleep_well_power_good,
	input logic [2:0] platform_state,
	input logic idle_criteria_met,
	input logic [1:0] engine_state,
	input logic s0_idle_indicator_n,
	input logic s4_sleep_indicator_n,
	input logic s5_sleep_indicator_n,
	input logic suspend_pin_level,
	input logic suspend_warn_mode,
	input logic core_voltage_select_bit0,
	input logic core_voltage_select_bit1,
	input logic ac_adapter_detect_o,
	input logic ac_adapter_detect_oe,
	input logic ac_adapter_detect_pd_en
);
	wire rst = !(resetn && resume_well_reset_n && deep_sleep_well_power_good);
	// Wells leave reset through synchronisers, so wait before judging
	reg [1:0] up_r;
	wire up = up_r == 2'h3;
	// Frozen cycles move nothing, so they are not judged
	wire ok = up && clk_en;
	wire [2:0] ps = platform_state;
	wire sx = ps == `SSPC_PS_S4 || ps == `SSPC_PS_S5;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) up_r <= 2'h0;
		else if (!up && clk_en) up_r <= up_r + 2'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_s0_idle_level: assert property (ok |=> s0_idle_indicator_n ==
		!($past(ps) == `SSPC_PS_S0I3 && $past(idle_criteria_met)))
		else $error("s0 idle level wrong");
	chk_s4_low_sx: assert property (ok && sx |=> !s4_sleep_indicator_n)
		else $error("s4 indicator not low");
	chk_s5_by_state: assert property (ok && sx |=>
		s5_sleep_indicator_n == ($past(ps) == `SSPC_PS_S4))
		else $error("s5 indicator wrong");
	chk_dsx_hold: assert property (ok && ps == `SSPC_PS_DSX |=>
		$stable(s4_sleep_indicator_n) && $stable(s5_sleep_indicator_n))
		else $error("indicators moved in deep sx");
	chk_ac_drive_low: assert property (disable iff (!resetn)
		ac_adapter_detect_oe |-> !ac_adapter_detect_o &&
		(!deep_sleep_well_power_good ||
		!$past(deep_sleep_well_power_good, 3)))
		else $error("ac pin driven outside well reset");
	chk_ack_zero_on: assert property (ok && !suspend_warn_mode &&
		engine_state != `SSPC_ENG_OFF |=> !suspend_pin_level)
		else $error("ack high with engine on");
	chk_pd_off_awake: assert property (ok && ps != `SSPC_PS_DSX |=>
		!ac_adapter_detect_pd_en)
		else $error("pull-down outside deep sx");
	chk_vid_high_sx: assert property (ok && sx |=>
		core_voltage_select_bit0 && core_voltage_select_bit1)
		else $error("voltage select not high");
	cover property (ok && ps == `SSPC_PS_DSX ##1 ps == `SSPC_PS_DSX);
	cover property (ac_adapter_detect_oe);
	cover property (suspend_warn_mode && !suspend_pin_level);
endmodule // sspc_chk
bind sspc_top sspc_chk i_chk (.*);

// file: sspc_platform.sv
// Board-side pad model for the deep idle gate and AC detect pins
`timescale 1ns/10ps
module sspc_platform (
	input logic processor_deep_idle_gate_n,
	input logic processor_deep_idle_gate_oe,
	input logic ac_adapter_detect_o,
	input logic ac_adapter_detect_oe,
	input logic ac_adapter_detect_pd_en,
	output logic gate_pad,
	output logic ac_pad
);
	// Board pull-up holds the gate high until the buffer drives it
	assign gate_pad = processor_deep_idle_gate_oe ?
		processor_deep_idle_gate_n : 1'h1;
	// No adapter fitted: only device drive or pull-down lowers it
	assign ac_pad = ac_adapter_detect_oe ? ac_adapter_detect_o :
		!ac_adapter_detect_pd_en;
endmodule // sspc_platform

// file: sspc_top_tb.sv
// Testbench for the sleep-state pin controller
`timescale 1ns/10ps
`include "sspc_regs.vh"
module sspc_top_tb;
	logic ref_clk, resetn, clk_en, resume_well_reset_n, rtc_well_reset_n;
	logic deep_sleep_well_power_good, idle_criteria_met, gate_native_en;
	logic powerdown_ack_req, suspend_warn_req, err, pready, pslverr;
	logic psel, penable, pwrite, platform_reset_n, s3_sleep_indicator_n;
	logic [2:0] platform_state;
	logic [1:0] engine_state;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic s0_idle_indicator_n, s4_sleep_indicator_n, s5_sleep_indicator_n;
	logic processor_deep_idle_gate_n, processor_deep_idle_gate_oe;
	logic always_on_domain_sleep_n, suspend_well_sleep_n;
	logic core_voltage_select_bit0, core_voltage_select_bit1;
	logic suspend_pin_level, suspend_warn_mode, ac_adapter_detect_o;
	logic ac_adapter_detect_oe, ac_adapter_detect_pd_en, gate_pad, ac_pad;
	logic network_wake_pd_en, pcie_wake_pd_en;
	logic [2:0] sq [5] = '{`SSPC_PS_S4, `SSPC_PS_S5, `SSPC_PS_DSX,
		`SSPC_PS_S4, `SSPC_PS_DSX};
	logic s5e [5] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1};
	int bad_count, n_compared;
	sspc_top i_dut (.*);
	sspc_platform i_plat (.*);
	////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		@(posedge ref_clk);
		while (pready !== 1'h1) @(posedge ref_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Pins follow one edge later; a well release needs three
	task automatic st(logic [2:0] s);
		platform_state <= s;
		repeat (4) @(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		end_sim();
	end
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, engine_state} = '0;
		{idle_criteria_met, powerdown_ack_req, suspend_warn_req} = '0;
		{clk_en, resume_well_reset_n, rtc_well_reset_n} = '1;
		{gate_native_en, deep_sleep_well_power_good} = 2'h1;
		platform_state = `SSPC_PS_S0;
		repeat (20) @(posedge ref_clk);
		resetn <= 1'h1;
		st(`SSPC_PS_S0);
		chk("vid", {core_voltage_select_bit1, core_voltage_select_bit0}, 2'h3);
		chk("warn", suspend_warn_mode, 1'h0);
		chk("gate", gate_pad, 1'h1);
		apb(1'h0, `SSPC_CFG_OFF, 32'h0);
		chk("cfg", rd, `SSPC_CFG_RST);
		apb(1'h0, 8'h08, 32'h0);
		chk("err", err, 1'h1);
		chk("rd", rd, 32'h0);
		st(`SSPC_PS_S0I3);
		chk("idle", s0_idle_indicator_n, 1'h1);
		idle_criteria_met <= 1'h1;
		st(`SSPC_PS_S0I3);
		chk("idle", s0_idle_indicator_n, 1'h0);
		gate_native_en <= 1'h1;
		apb(1'h1, `SSPC_CFG_OFF, 32'h0D);
		st(`SSPC_PS_S0);
		chk("vid", {core_voltage_select_bit1, core_voltage_select_bit0}, 2'h0);
		for (int i = 0; i < 5; i++) begin
			st(sq[i]);
			chk("s4", s4_sleep_indicator_n, 1'h0);
			chk("s5", s5_sleep_indicator_n, s5e[i]);
			chk("aon", always_on_domain_sleep_n, 1'h1);
			chk("vid", {core_voltage_select_bit1, core_voltage_select_bit0}, 2'h3);
			chk("gate", gate_pad, 1'h0);
			chk("s3", s3_sleep_indicator_n, 1'h0);
			chk("sus", suspend_well_sleep_n, sq[i] != `SSPC_PS_DSX);
			chk("pd", {pcie_wake_pd_en, network_wake_pd_en, ac_pad},
				sq[i] == `SSPC_PS_DSX ? 3'h4 : 3'h1);
		end
		apb(1'h1, `SSPC_CFG_OFF, 32'h10);
		engine_state <= `SSPC_ENG_OFF;
		powerdown_ack_req <= 1'h1;
		st(`SSPC_PS_S5);
		chk("aon", always_on_domain_sleep_n, 1'h0);
		chk("ack", suspend_pin_level, 1'h1);
		engine_state <= `SSPC_ENG_LOW_PWR;
		st(`SSPC_PS_S5);
		chk("ack", suspend_pin_level, 1'h0);
		resume_well_reset_n <= 1'h0;
		@(posedge ref_clk);
		resume_well_reset_n <= 1'h1;
		suspend_warn_req <= 1'h1;
		st(`SSPC_PS_S0);
		chk("warn", {suspend_warn_mode, suspend_pin_level}, 2'h2);
		deep_sleep_well_power_good <= 1'h0;
		st(`SSPC_PS_S0);
		chk("well", {platform_reset_n, s4_sleep_indicator_n}, 2'h2);
		chk("ac", {ac_adapter_detect_oe, ac_pad}, 2'h2);
		deep_sleep_well_power_good <= 1'h1;
		st(`SSPC_PS_S0);
		chk("s4", s4_sleep_indicator_n, 1'h1);
		apb(1'h1, `SSPC_CFG_OFF, 32'h90);
		deep_sleep_well_power_good <= 1'h0;
		st(`SSPC_PS_S0);
		chk("acdsx", {ac_adapter_detect_oe, ac_pad}, 2'h1);
		deep_sleep_well_power_good <= 1'h1;
		st(`SSPC_PS_S0);
		clk_en <= 1'h0;
		st(`SSPC_PS_S5);
		chk("frz", s4_sleep_indicator_n, 1'h1);
		clk_en <= 1'h1;
		st(`SSPC_PS_S5);
		chk("s4", s4_sleep_indicator_n, 1'h0);
		st(3'h7);
		chk("hold", {s4_sleep_indicator_n, s5_sleep_indicator_n}, 2'h0);
		end_sim();
	end
endmodule // sspc_top_tb
